// ---- core/sscp_map.svh ----
`ifndef SSCP_MAP_SVH
`define SSCP_MAP_SVH

// Register offsets
`define SSCP_ADDR_CTRL      4'h0
`define SSCP_ADDR_CHAR      4'h4
`define SSCP_ADDR_STAT      4'h8

// CTRL fields
`define SSCP_CTRL_EN_BIT    0
`define SSCP_CTRL_CRLF_BIT  1
`define SSCP_CTRL_DIAG_BIT  2
`define SSCP_CTRL_PLEN_LSB  8

// Reset values
`define SSCP_RST_CMD_EN     1'b1
`define SSCP_RST_CRLF_EN    1'b1
`define SSCP_RST_DIAG_EN    1'b0
`define SSCP_RST_PLEN       8'h03
`define SSCP_RST_CHAR_CYC   16'hA2C3

// Pause length limits, in character times
`define SSCP_PLEN_MIN       8'h03

// Pause ceiling
`define SSCP_CLK_NS         25
`define SSCP_PAUSE_MAX_MS   170
`define SSCP_PAUSE_MAX_CYC  ((`SSCP_PAUSE_MAX_MS * 1000000) / `SSCP_CLK_NS)

// Command buffer and sequences
`define SSCP_BUF_DEPTH      32
`define SSCP_SEQ_LAST       2'h2

// Characters
`define SSCP_CH_PLUS        8'h2B
`define SSCP_CH_MINUS       8'h2D
`define SSCP_CH_S           8'h53
`define SSCP_CH_L           8'h4C
`define SSCP_CH_CR          8'h0D
`define SSCP_CH_LF          8'h0A
`define SSCP_CH_O           8'h4F
`define SSCP_CH_K           8'h4B

`endif

// ---- core/sscp_parser.sv ----
// Functional notes
// - Commands interpreted only when enable set
// - Command framed by idle pauses of pause length
// - Accept command ended by CR or CRLF
// - Every command answered by executor response
// - Second port commands only in diagnostics function
// - Response returns on command's own port
// - Append CRLF to responses lacking it
// - Data starting with prefix becomes command
// - Command enable on after reset
// - Forced mode enables commands, stops radio
// - Leaving forced mode restores enable and radio
// - Three spaced plus characters enter forced mode
// - Three spaced minus characters leave forced mode
// - Commands use normal data framing and baud
// - Pause means no transitions on input line
// - Pause length ranges three to 255 chars
// - Pause time clamped to 170 ms
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sscp_map.svh"
module sscp_parser #(
  parameter int PAUSE_MAX_CYC = `SSCP_PAUSE_MAX_CYC
) (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire sscp_pkg::sscp_bus_t  bus,
  output logic [31:0]            reg_rdata,
  input  wire logic              host_to_module_line,
  input  wire logic              second_port_host_to_module,
  input  wire sscp_pkg::sscp_byte_t rx1,
  input  wire sscp_pkg::sscp_byte_t rx2,
  output sscp_pkg::sscp_byte_t   data_out,
  output logic                   radio_enable,
  output sscp_pkg::sscp_byte_t   cmd_out,
  output logic                   cmd_last,
  input  wire sscp_pkg::sscp_byte_t resp,
  input  wire logic              resp_last,
  output logic                   resp_ready,
  output logic [1:0]             tx_valid,
  output logic [7:0]             tx_data,
  input  wire logic [1:0]        tx_ready
);
  import sscp_pkg::*;

  typedef struct packed {
    sscp_state_t st;
    logic        cmd_en;
    logic        crlf_en;
    logic        diag_en;
    logic [7:0]  plen;
    logic [15:0] char_cyc;
    logic        forced;
    logic        port;
    logic [1:0]  gap;
    logic [7:0]  hold;
    logic [1:0]  seq_cnt;
    logic [5:0]  len;
    logic [5:0]  idx;
    logic [`SSCP_BUF_DEPTH-1:0][7:0] buffer;
    logic [15:0] last2;
    logic [31:0] rdata;
    logic        data_v;
    logic [7:0]  data_b;
    logic        cmd_v;
    logic        cmd_l;
    logic [7:0]  cmd_b;
    logic        tx_v;
    logic [7:0]  tx_b;
  } sscp_core_t;

  sscp_core_t r;
  sscp_core_t next_r;

  logic [23:0] prod;
  logic [23:0] thr;
  logic [1:0]  rise;
  logic [1:0]  lines;
  logic        in_v;
  logic        in_p;
  logic [7:0]  in_b;
  logic        in_gap;
  logic        eff_en;
  logic        load_ok;
  logic        end_rise;

  assign prod = 24'(r.plen) * 24'(r.char_cyc);
  assign thr  = (prod > 24'(PAUSE_MAX_CYC)) ? 24'(PAUSE_MAX_CYC) : prod;

  assign lines = {second_port_host_to_module, host_to_module_line};

  // One pause detector per serial port
  for (genvar g = 0; g < 2; g++) begin : g_pause
    sscp_pause_det sscp_pause_det_inst (
      .core_clk   (core_clk),
      .rst_n      (rst_n),
      .line       (lines[g]),
      .thr        (thr),
      .pause_rise (rise[g])
    );
  end

  // Input byte selection; port 2 only in diagnostics
  always_comb begin
    in_v = 1'b0;
    in_p = r.port;
    in_b = rx1.data;
    if (r.st == ST_IDLE) begin
      if (rx1.valid) begin
        in_v = 1'b1;
        in_p = 1'b0;
      end else if (rx2.valid && r.diag_en) begin
        in_v = 1'b1;
        in_p = 1'b1;
        in_b = rx2.data;
      end
    end else if (r.port) begin
      in_v = rx2.valid && r.diag_en;
      in_b = rx2.data;
    end else begin
      in_v = rx1.valid;
    end
  end

  // Pause ending in the byte's own cycle still counts
  assign in_gap   = r.gap[in_p] | rise[in_p];
  assign eff_en   = r.cmd_en | r.forced;
  assign load_ok  = !r.tx_v || tx_ready[r.port];
  assign end_rise = rise[r.port];

  always_comb begin
    next_r        = r;
    next_r.data_v = 1'b0;
    next_r.cmd_v  = 1'b0;
    next_r.cmd_l  = 1'b0;
    next_r.rdata  = 32'h00000000;
    if (r.tx_v && tx_ready[r.port]) begin
      next_r.tx_v = 1'b0;
    end
    for (int i = 0; i < 2; i++) begin
      if (rise[i]) begin
        next_r.gap[i] = 1'b1;
      end
    end
    if (in_v) begin
      next_r.gap[in_p] = 1'b0;
    end

    // Register port
    if (bus.wr) begin
      if (bus.addr == `SSCP_ADDR_CTRL) begin
        next_r.cmd_en  = bus.wdata[`SSCP_CTRL_EN_BIT];
        next_r.crlf_en = bus.wdata[`SSCP_CTRL_CRLF_BIT];
        next_r.diag_en = bus.wdata[`SSCP_CTRL_DIAG_BIT];
        next_r.plen    = bus.wdata[`SSCP_CTRL_PLEN_LSB +: 8];
        if (bus.wdata[`SSCP_CTRL_PLEN_LSB +: 8] < `SSCP_PLEN_MIN) begin
          next_r.plen = `SSCP_PLEN_MIN;
        end
      end else if (bus.addr == `SSCP_ADDR_CHAR) begin
        next_r.char_cyc = bus.wdata[15:0];
        if (bus.wdata[15:0] == 16'h0000) begin
          next_r.char_cyc = 16'h0001;
        end
      end
    end
    if (bus.rd) begin
      if (bus.addr == `SSCP_ADDR_CTRL) begin
        next_r.rdata = {16'h0000, r.plen, 5'h00, r.diag_en, r.crlf_en, r.cmd_en};
      end else if (bus.addr == `SSCP_ADDR_CHAR) begin
        next_r.rdata = {16'h0000, r.char_cyc};
      end else if (bus.addr == `SSCP_ADDR_STAT) begin
        next_r.rdata = {20'h00000, r.seq_cnt, r.port, r.forced, 4'(r.st), 4'h0};
      end
    end

    case (r.st)
      ST_IDLE: begin
        if (in_v) begin
          next_r.port = in_p;
          if (in_gap && ((in_b == `SSCP_CH_PLUS && !r.forced) ||
                         (in_b == `SSCP_CH_MINUS && r.forced) ||
                         (in_b == `SSCP_CH_S && eff_en))) begin
            next_r.hold = in_b;
            next_r.st   = ST_HOLD;
          end else begin
            next_r.seq_cnt = 2'h0;
            next_r.data_v  = !in_p && !r.forced;
            next_r.data_b  = in_b;
            next_r.st      = in_p ? ST_IDLE : ST_PASS;
          end
        end
      end
      ST_HOLD: begin
        if (in_v) begin
          next_r.seq_cnt = 2'h0;
          if (r.hold == `SSCP_CH_S && in_b == `SSCP_CH_L) begin
            next_r.buffer[0] = `SSCP_CH_S;
            next_r.buffer[1] = `SSCP_CH_L;
            next_r.len       = 6'd2;
            next_r.st        = ST_CMD;
          end else begin
            next_r.data_v = !r.port && !r.forced;
            next_r.data_b = r.hold;
            next_r.hold   = in_b;
            next_r.st     = ST_FLUSH;
          end
        end else if (end_rise) begin
          if (r.hold == `SSCP_CH_S) begin
            next_r.data_v  = !r.port && !r.forced;
            next_r.data_b  = r.hold;
            next_r.seq_cnt = 2'h0;
            next_r.st      = ST_IDLE;
          end else if (r.seq_cnt == `SSCP_SEQ_LAST) begin
            next_r.forced  = !r.forced;
            next_r.seq_cnt = 2'h0;
            next_r.st      = ST_OK_O;
          end else begin
            next_r.seq_cnt = r.seq_cnt + 2'h1;
            next_r.st      = ST_IDLE;
          end
        end
      end
      ST_FLUSH: begin
        next_r.data_v = !r.port && !r.forced;
        next_r.data_b = r.hold;
        next_r.st     = ST_PASS;
      end
      ST_PASS: begin
        if (in_v) begin
          next_r.data_v = !r.forced;
          next_r.data_b = in_b;
        end else if (end_rise) begin
          next_r.st = ST_IDLE;
        end
      end
      ST_CMD: begin
        if (in_v && r.len < 6'(`SSCP_BUF_DEPTH)) begin
          next_r.buffer[r.len[4:0]] = in_b;
          next_r.len                = r.len + 6'd1;
        end else if (end_rise) begin
          next_r.idx = 6'd0;
          next_r.st  = ST_EXEC;
          if (r.buffer[5'(r.len - 6'd1)] == `SSCP_CH_CR) begin
            next_r.len = r.len - 6'd1;
          end else if (r.buffer[5'(r.len - 6'd1)] == `SSCP_CH_LF &&
                       r.buffer[5'(r.len - 6'd2)] == `SSCP_CH_CR) begin
            next_r.len = r.len - 6'd2;
          end
        end
      end
      ST_EXEC: begin
        next_r.cmd_v = 1'b1;
        next_r.cmd_b = r.buffer[r.idx[4:0]];
        next_r.idx   = r.idx + 6'd1;
        if (r.idx + 6'd1 == r.len) begin
          next_r.cmd_l = 1'b1;
          next_r.last2 = 16'h0000;
          next_r.st    = ST_RESP;
        end
      end
      ST_RESP: begin
        if (resp.valid && load_ok) begin
          next_r.tx_v  = 1'b1;
          next_r.tx_b  = resp.data;
          next_r.last2 = {r.last2[7:0], resp.data};
          if (resp_last) begin
            if (!r.crlf_en || {r.last2[7:0], resp.data} ==
                              {`SSCP_CH_CR, `SSCP_CH_LF}) begin
              next_r.st = ST_IDLE;
            end else if (resp.data == `SSCP_CH_CR) begin
              next_r.st = ST_APPEND_LF;
            end else begin
              next_r.st = ST_APPEND_CR;
            end
          end
        end
      end
      ST_OK_O: begin
        if (load_ok) begin
          next_r.tx_v = 1'b1;
          next_r.tx_b = `SSCP_CH_O;
          next_r.st   = ST_OK_K;
        end
      end
      ST_OK_K: begin
        if (load_ok) begin
          next_r.tx_v = 1'b1;
          next_r.tx_b = `SSCP_CH_K;
          next_r.st   = r.crlf_en ? ST_APPEND_CR : ST_IDLE;
        end
      end
      ST_APPEND_CR: begin
        if (load_ok) begin
          next_r.tx_v = 1'b1;
          next_r.tx_b = `SSCP_CH_CR;
          next_r.st   = ST_APPEND_LF;
        end
      end
      ST_APPEND_LF: begin
        if (load_ok) begin
          next_r.tx_v = 1'b1;
          next_r.tx_b = `SSCP_CH_LF;
          next_r.st   = ST_IDLE;
        end
      end
      default: begin
        next_r.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r          <= '0;
      r.st       <= ST_IDLE;
      r.cmd_en   <= `SSCP_RST_CMD_EN;
      r.crlf_en  <= `SSCP_RST_CRLF_EN;
      r.diag_en  <= `SSCP_RST_DIAG_EN;
      r.plen     <= `SSCP_RST_PLEN;
      r.char_cyc <= `SSCP_RST_CHAR_CYC;
    end else begin
      r <= next_r;
    end
  end

  assign reg_rdata      = r.rdata;
  assign radio_enable   = !r.forced;
  assign data_out       = '{valid: r.data_v, data: r.data_b};
  assign cmd_out        = '{valid: r.cmd_v, data: r.cmd_b};
  assign cmd_last       = r.cmd_l;
  assign resp_ready     = (r.st == ST_RESP) && load_ok;
  assign tx_valid       = {r.tx_v && r.port, r.tx_v && !r.port};
  assign tx_data        = r.tx_b;

  property p_disabled_no_hold;
    @(posedge core_clk) disable iff (!rst_n)
    (r.st == ST_IDLE && in_v && in_b == `SSCP_CH_S && !r.cmd_en && !r.forced)
      |=> r.st != ST_HOLD;
  endproperty
  a_disabled_no_hold: assert property (p_disabled_no_hold) else $error("prefix held while disabled");

  property p_forced_no_data;
    @(posedge core_clk) disable iff (!rst_n)
    r.forced && $past(r.forced) |-> !data_out.valid;
  endproperty
  a_forced_no_data: assert property (p_forced_no_data) else $error("data forwarded in forced mode");

  property p_radio_off;
    @(posedge core_clk) disable iff (!rst_n)
    $rose(r.forced) |-> !radio_enable ##0 r.st == ST_OK_O;
  endproperty
  a_radio_off: assert property (p_radio_off) else $error("radio not suspended");

  property p_enter;
    @(posedge core_clk) disable iff (!rst_n)
    (r.st == ST_HOLD && !in_v && end_rise && r.hold == `SSCP_CH_PLUS && r.seq_cnt == 2'h2)
      |=> r.forced ##[1:4] (tx_data == `SSCP_CH_O && |tx_valid);
  endproperty
  a_enter: assert property (p_enter) else $error("plus sequence did not enter");

  property p_leave;
    @(posedge core_clk) disable iff (!rst_n)
    (r.st == ST_HOLD && !in_v && end_rise && r.hold == `SSCP_CH_MINUS && r.seq_cnt == 2'h2)
      |=> !r.forced && radio_enable;
  endproperty
  a_leave: assert property (p_leave) else $error("minus sequence did not leave");

  property p_plen_range;
    @(posedge core_clk) disable iff (!rst_n)
    r.plen >= `SSCP_PLEN_MIN;
  endproperty
  a_plen_range: assert property (p_plen_range) else $error("pause length below minimum");

  property p_clamp;
    @(posedge core_clk) disable iff (!rst_n)
    thr <= 24'(PAUSE_MAX_CYC) && thr != 24'h000000;
  endproperty
  a_clamp: assert property (p_clamp) else $error("pause threshold out of range");

  property p_second_serial_port_off;
    @(posedge core_clk) disable iff (!rst_n)
    (r.st == ST_IDLE && !rx1.valid && rx2.valid && !r.diag_en) |=> r.st == ST_IDLE;
  endproperty
  a_second_serial_port_off: assert property (p_second_serial_port_off) else $error("second port used while off");

  property p_exec_resp;
    @(posedge core_clk) disable iff (!rst_n)
    cmd_last |-> r.st == ST_RESP && $past(r.st) == ST_EXEC;
  endproperty
  a_exec_resp: assert property (p_exec_resp) else $error("command end not followed by response");

  property p_append_lf;
    @(posedge core_clk) disable iff (!rst_n)
    (r.st == ST_APPEND_CR && load_ok) |=> tx_data == `SSCP_CH_CR ##[1:300] tx_data == `SSCP_CH_LF;
  endproperty
  a_append_lf: assert property (p_append_lf) else $error("line ending incomplete");

  c_forced: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(r.forced));
  c_cmd:    cover property (@(posedge core_clk) disable iff (!rst_n) cmd_last);
  c_second_serial_port:  cover property (@(posedge core_clk) disable iff (!rst_n) tx_valid[1]);

endmodule
`default_nettype wire

// ---- core/sscp_pause_det.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sscp_map.svh"
module sscp_pause_det (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        line,
  input  wire logic [23:0] thr,
  output logic             pause_rise
);
  import sscp_pkg::*;

  typedef struct packed {
    logic        s1;
    logic        s2;
    logic        s3;
    logic [23:0] cnt;
    logic        rise;
  } sscp_pd_t;

  sscp_pd_t r;
  sscp_pd_t next_r;

  // Pause is time with no level change on the line
  always_comb begin
    next_r      = r;
    next_r.s1   = line;
    next_r.s2   = r.s1;
    next_r.s3   = r.s2;
    next_r.rise = 1'b0;
    if (r.s2 != r.s3) begin
      next_r.cnt = 24'h000000;
    end else if (r.cnt < thr) begin
      next_r.cnt  = r.cnt + 24'h000001;
      next_r.rise = (r.cnt + 24'h000001 == thr);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, cnt: 24'h000000, rise: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign pause_rise = r.rise;

endmodule
`default_nettype wire

// ---- core/sscp_pkg.sv ----
package sscp_pkg;

  typedef enum logic [3:0] {
    ST_IDLE, ST_HOLD, ST_FLUSH, ST_PASS, ST_CMD, ST_EXEC,
    ST_RESP, ST_OK_O, ST_OK_K, ST_APPEND_CR, ST_APPEND_LF
  } sscp_state_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } sscp_byte_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } sscp_bus_t;

endpackage

// ---- dv/serial_setting_command_parser_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sscp_map.svh"
module serial_setting_command_parser_tb_top;
  import sscp_pkg::*;
  localparam int PMAX = 200;
  logic        core_clk;
  logic        rst_n;
  sscp_bus_t   bus;
  logic [31:0] reg_rdata;
  logic        line1, line2, cmd_last, resp_last, resp_ready, radio_enable;
  sscp_byte_t  rx1, rx2, data_out, cmd_out, resp;
  logic [1:0]  tx_valid, tx_ready;
  logic [7:0]  tx_data, last_cmd;
  logic [7:0]  dq[$], cq[$], tq0[$], tq1[$];
  string       rsp = "OK";
  int          ri = -1;
  int          n_errors = 0;
  int          samples_checked = 0;

  sscp_parser #(.PAUSE_MAX_CYC(PMAX)) sscp_parser_inst (
    .core_clk(core_clk), .rst_n(rst_n), .bus(bus), .reg_rdata(reg_rdata),
    .host_to_module_line(line1), .second_port_host_to_module(line2),
    .rx1(rx1), .rx2(rx2), .data_out(data_out), .radio_enable(radio_enable),
    .cmd_out(cmd_out), .cmd_last(cmd_last), .resp(resp), .resp_last(resp_last),
    .resp_ready(resp_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready)
  );
  sscp_host_model host_p1 (.core_clk(core_clk), .line(line1), .rx(rx1));
  sscp_host_model host_p2 (.core_clk(core_clk), .line(line2), .rx(rx2));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // Sink stalls every other cycle, ports out of phase
  always @(posedge core_clk) tx_ready <= ~tx_ready;
  // Executor answers each command with rsp
  always @(posedge core_clk) begin
    if (cmd_last) ri = 0;
    else if (resp.valid && resp_ready) ri = ri + 1;
    if (ri >= rsp.len()) ri = -1;
    resp      <= (ri >= 0) ? {1'b1, rsp[ri]} : 9'h000;
    resp_last <= (ri >= 0) && (ri == rsp.len() - 1);
  end
  always @(posedge core_clk) begin
    if (data_out.valid) dq.push_back(data_out.data);
    if (cmd_out.valid) cq.push_back(cmd_out.data);
    if (cmd_last) last_cmd = cmd_out.data;
    if (tx_valid[0] && tx_ready[0]) tq0.push_back(tx_data);
    if (tx_valid[1] && tx_ready[1]) tq1.push_back(tx_data);
  end

  task automatic results();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic qchk(input string nm, input string e, ref logic [7:0] q[$]);
    string g;
    bit    bad;
    g = "";
    bad = (q.size() != e.len());
    samples_checked++;
    foreach (q[i]) begin
      g = {g, $sformatf("%h ", q[i])};
      if (!bad && q[i] !== e[i]) bad = 1'b1;
    end
    if (bad) begin
      n_errors++;
      $display("ERROR %s expected %0d bytes seen %0d bytes: %s", nm, e.len(), q.size(), g);
    end
    q.delete();
  endtask
  task automatic wait_q(ref logic [7:0] q[$], input int n);
    int k;
    for (k = 0; k < 3000 && q.size() < n; k++) @(posedge core_clk);
    if (q.size() < n) begin
      n_errors++;
      $display("ERROR response wait expected %0d bytes seen %0d", n, q.size());
      results();
    end
    repeat (20) @(posedge core_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus.rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic t_reset();
    logic [31:0] d;
    chk("radio_enable", 32'h1, {31'h0, radio_enable});
    rd(`SSCP_ADDR_CTRL, d);
    chk("ctrl reset", 32'h0000_0303, d);
    rd(`SSCP_ADDR_CHAR, d);
    chk("char reset", 32'h0000_A2C3, d);
    rd(4'hC, d);
    chk("unmapped read", 32'h0, d);
    wr(`SSCP_ADDR_CHAR, 32'h0000_0004);
    wr(`SSCP_ADDR_CTRL, 32'h0000_0103);
    rd(`SSCP_ADDR_CTRL, d);
    chk("pause floor", 32'h0000_0303, d);
  endtask
  task automatic t_cmd();
    rsp = "OK";
    host_p1.str("SLX\r\n");
    wait_q(tq0, 4);
    qchk("port1 response", "OK\r\n", tq0);
    chk("last command byte", 32'h58, {24'h0, last_cmd});
    qchk("command bytes", "SLX", cq);
    qchk("radio data", "", dq);
    rsp = "12\r";
    host_p1.str("SLQ\r");
    wait_q(tq0, 4);
    qchk("cr ending", "12\r\n", tq0);
    qchk("cr stripped", "SLQ", cq);
    rsp = "7\r\n";
    host_p1.str("SLQ");
    wait_q(tq0, 3);
    qchk("crlf kept", "7\r\n", tq0);
    wr(`SSCP_ADDR_CTRL, 32'h0000_0301);
    rsp = "OK";
    host_p1.str("SLQ");
    wait_q(tq0, 2);
    qchk("no line ending", "OK", tq0);
    host_p1.str("SQ");
    qchk("prefix then data", "SQ", dq);
    host_p1.str("S");
    qchk("lone prefix", "S", dq);
    cq.delete();
  endtask
  task automatic t_off();
    wr(`SSCP_ADDR_CTRL, 32'h0000_0302);
    host_p1.str("SLA");
    qchk("data when disabled", "SLA", dq);
    qchk("commands when disabled", "", cq);
  endtask
  task automatic t_second_serial_port();
    wr(`SSCP_ADDR_CTRL, 32'h0000_0303);
    host_p2.str("SLB");
    qchk("second_serial_port off commands", "", cq);
    qchk("second_serial_port off data", "", dq);
    wr(`SSCP_ADDR_CTRL, 32'h0000_0307);
    host_p2.str("SLB");
    wait_q(tq1, 4);
    qchk("second_serial_port response", "OK\r\n", tq1);
    qchk("port1 idle", "", tq0);
    cq.delete();
  endtask
  task automatic t_forced();
    logic [31:0] d;
    wr(`SSCP_ADDR_CTRL, 32'h0000_0302);
    host_p1.str("+++");
    qchk("unspaced plus", "+++", dq);
    chk("radio kept", 32'h1, {31'h0, radio_enable});
    host_p1.spaced("+");
    wait_q(tq0, 4);
    qchk("enter reply", "OK\r\n", tq0);
    chk("radio off", 32'h0, {31'h0, radio_enable});
    rd(`SSCP_ADDR_STAT, d);
    chk("status forced", 32'h0000_0100, d);
    host_p1.str("A");
    qchk("forced data", "", dq);
    host_p1.str("SLC");
    wait_q(tq0, 4);
    qchk("forced command reply", "OK\r\n", tq0);
    chk("forced command byte", 32'h43, {24'h0, last_cmd});
    host_p1.spaced("-");
    wait_q(tq0, 4);
    qchk("exit reply", "OK\r\n", tq0);
    chk("radio on", 32'h1, {31'h0, radio_enable});
    host_p1.str("SLD");
    qchk("restored disable", "SLD", dq);
    cq.delete();
  endtask
  task automatic t_clamp();
    logic [31:0] d;
    wr(`SSCP_ADDR_CTRL, 32'h0000_FF03);
    rd(`SSCP_ADDR_CTRL, d);
    chk("pause max", 32'h0000_FF03, d);
    host_p1.gap_n = 230;
    host_p1.str("SLE");
    qchk("clamped command", "SLE", cq);
    wait_q(tq0, 4);
    qchk("clamped pause", "OK\r\n", tq0);
    host_p1.gap_n = 30;
  endtask

  initial begin
    bus       = '0;
    rst_n     = 1'b0;
    tx_ready  = 2'b01;
    resp      = '0;
    resp_last = 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_cmd();
    t_off();
    t_second_serial_port();
    t_forced();
    t_clamp();
    results();
  end
endmodule
`default_nettype wire

// ---- dv/sscp_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module sscp_host_model (
  input  wire logic              core_clk,
  output logic                   line,
  output var sscp_pkg::sscp_byte_t rx
);
  import sscp_pkg::*;
  int gap_n = 30;
  initial begin
    line = 1'b1;
    rx   = '0;
  end
  // One character: start and stop edges on the line, one-cycle strobe
  task automatic send(input logic [7:0] b);
    @(posedge core_clk);
    line <= 1'b0;
    rx   <= {1'b1, b};
    @(posedge core_clk);
    line <= 1'b1;
    rx   <= '0;
  endtask
  // Quiet line, no edges at all
  task automatic quiet();
    repeat (gap_n) @(posedge core_clk);
  endtask
  // Unbroken string, nothing trailing before the closing pause
  task automatic str(input string s);
    quiet();
    foreach (s[i]) send(s[i]);
    quiet();
  endtask
  // Called only while no other traffic is on the line
  task automatic spaced(input logic [7:0] c);
    repeat (3) begin
      quiet();
      send(c);
    end
    quiet();
  endtask
endmodule
`default_nettype wire
